// ==== rtl/acslu_defines.svh ====
// Constants of the accumulator shift and logic unit: opcode words, opcode fields and sizes.
// Assumes it is included by the package, the datapath module and the bench.
`ifndef ACSLU_DEFINES_SVH
`define ACSLU_DEFINES_SVH

// Full 16-bit instruction words of the fixed-code operations.
`define ACSLU_OP_ROT_R       16'h8ACA
`define ACSLU_OP_ROT_RC      16'h8ADA
`define ACSLU_OP_SHL_1       16'h8A2A
`define ACSLU_OP_SHL_2       16'h8A3A
`define ACSLU_OP_SHL_4       16'h8A6A
`define ACSLU_OP_SHR_LOG     16'h8AAA
`define ACSLU_OP_SHR_AR1     16'h8AFA
`define ACSLU_OP_SHR_AR2     16'h8AEA
`define ACSLU_OP_SHR_AR4     16'h8ABA
`define ACSLU_OP_BYTE_SWP    16'h8A8A
`define ACSLU_OP_NIB_SWP     16'h8A7A

// Source-operand forms: bits 14:8 of the word, bit 15 only chooses the source kind.
`define ACSLU_FLD_SUB        7'h5A
`define ACSLU_FLD_MINUS_SOURCE_BORROW       7'h7A
`define ACSLU_FLD_XOR        7'h3A

// Carry-with-bit form: bits 15:8 and 3:0 fixed, bits 7:4 carry the bit index.
`define ACSLU_FLD_BIT_HI     8'hBA
`define ACSLU_FLD_BIT_LO     4'hA

// Sizes: accumulator width of the wide variant and number of accumulators.
`define ACSLU_ACC_W          16
`define ACSLU_NUM_ACC        16
`define ACSLU_PTR_W          4

`endif

// ==== rtl/acslu_pkg.sv ====
// Types of the accumulator shift and logic unit: decoded operation kinds and the flag group.
// Assumes acslu_defines.svh is on the include path.
`include "acslu_defines.svh"

package acslu_pkg;

  // Decoded operation kind, one-hot so that each flag-update term is a single bit test.
  typedef enum logic [14:0] {
    ACSLU_K_NONE  = 15'h0001,
    ACSLU_K_RR    = 15'h0002,
    ACSLU_K_RRC   = 15'h0004,
    ACSLU_K_SHL1  = 15'h0008,
    ACSLU_K_SHL2  = 15'h0010,
    ACSLU_K_SHL4  = 15'h0020,
    ACSLU_K_SHRL  = 15'h0040,
    ACSLU_K_SHRA1 = 15'h0080,
    ACSLU_K_SHRA2 = 15'h0100,
    ACSLU_K_SHRA4 = 15'h0200,
    ACSLU_K_SUB   = 15'h0400,
    ACSLU_K_MINUS_SOURCE_BORROW  = 15'h0800,
    ACSLU_K_BSWP  = 15'h1000,
    ACSLU_K_NSWP  = 15'h2000,
    ACSLU_K_XORS  = 15'h4000
  } acslu_kind_t;

  // Status flags: carry, negative, null result and signed range fault.
  typedef struct packed {
    logic c;
    logic s;
    logic z;
    logic ov;
  } acslu_flags_t;

endpackage : acslu_pkg

// ==== rtl/acslu_datapath.sv ====
// Accumulator datapath: holds the accumulators, executes one shift, rotate, subtract or XOR per cycle.
// Assumes the instruction decoder drives op_valid with op_word, the source operand and the flags
// on the core clock, and keeps the flag storage itself; all inputs are from the same clock domain.
`timescale 1ns/1ps
`include "acslu_defines.svh"

// Summary of operation
// - Rotate right: old lsb into msb.
// - Rotate through carry: carry in, lsb out.
// - Rotate sets S; carry rotate sets C,S,Z.
// - Left shifts by one, two, four.
// - Left shift: zero in, last msb to carry.
// - Logical right shift inserts zero msb.
// - Arithmetic right shifts replicate the msb.
// - Right shifts: departing lsb to carry.
// - Right shifts set Z; S only logical.
// - Subtract source, update C,S,Z,OV.
// - Subtract source and carry borrow.
// - Byte source high byte from prefix.
// - Byte swap, wide variant only, sets S.
// - Nibble swap per byte, sets S.
// - XOR with source, sets S,Z.
// - Pointer selects active accumulator for ops.
// - Carry XOR selected accumulator bit, only C.
// - Narrow variant takes bit index 0..7 only.
module acslu_datapath
  import acslu_pkg::*;
#(
  parameter int ACC_W   = `ACSLU_ACC_W,   // Accumulator width: 8 or 16.
  parameter int NUM_ACC = `ACSLU_NUM_ACC, // Number of accumulators.
  parameter int PTR_W   = `ACSLU_PTR_W    // Width of the accumulator pointer.
) (
  input  wire  logic               clk,          // Core clock, 100 MHz.
  input  wire  logic               sys_rst,      // Synchronous reset, active high.
  input  wire  logic               op_valid,     // Instruction word is valid this cycle.
  input  wire  logic [15:0]        op_word,      // Instruction word.
  input  wire  logic [PTR_W-1:0]   acc_pointer,  // Selects the active accumulator.
  input  wire  logic [ACC_W-1:0]   src_data,     // Source operand.
  input  wire  logic               src_is_byte,  // Source operand is only 8 bits wide.
  input  wire  logic [7:0]         prefix_hi,    // Prefix register contents for the high byte.
  input  wire  acslu_flags_t       flags_in,     // Current flag values from flag storage.
  input  wire  logic [PTR_W-1:0]   bus_addr,     // Accumulator index for bus access.
  input  wire  logic [15:0]        bus_wdata,    // Bus write data.
  input  wire  logic               bus_wr,       // Bus write strobe.
  input  wire  logic               bus_rd,       // Bus read strobe.
  output logic [15:0]              bus_rdata,    // Bus read data, one cycle after the strobe.
  output logic [ACC_W-1:0]         result,       // Value written back by the last operation.
  output acslu_flags_t             flags_out,    // New flag values.
  output acslu_flags_t             flags_upd,    // Which flags the last operation updated.
  output logic                     op_done,      // Pulse: an operation completed.
  output logic                     op_illegal    // Pulse: word not executed by this variant.
);

  // Accumulator array; the datapath is the only writer apart from the bus port.
  logic [ACC_W-1:0]   acc_q [NUM_ACC];    // Accumulator contents.
  logic [ACC_W-1:0]   acc_d [NUM_ACC];    // Next accumulator contents.

  // Registered outputs and their next values.
  logic [15:0]        rdata_q, rdata_d;   // Read data.
  logic [ACC_W-1:0]   res_q, res_d;       // Last written value.
  acslu_flags_t       fl_q, fl_d;         // Flag values.
  acslu_flags_t       up_q, up_d;         // Flag update mask.
  logic               done_q, done_d;     // Completion pulse.
  logic               ill_q, ill_d;       // Illegal word pulse.

  // Decode results.
  acslu_kind_t        kind;               // Decoded operation with acc write-back.
  logic               bit_op;             // Carry XOR bit form.
  logic [3:0]         bit_idx;            // Bit index of that form.
  logic               illegal;            // Word unrecognised or not legal here.

  // Operand and results.
  logic [ACC_W-1:0]   acc;                // Active accumulator value.
  logic [ACC_W-1:0]   opnd;               // Source operand after widening.
  logic [ACC_W:0]     diff;               // Subtract result with borrow bit.
  logic [ACC_W-1:0]   nswap;              // Nibble-swapped accumulator.
  logic [ACC_W-1:0]   res;                // Combinational result.
  logic               new_c;              // Combinational carry.

  // Active accumulator is the one the pointer names.
  assign acc = acc_q[acc_pointer];

  // A byte source on the wide variant takes its high byte from the prefix register.
  // The decoder never names the active accumulator here, so no read-write hazard exists.
  always_comb begin
    opnd = src_data;
    if (ACC_W == 16 && src_is_byte) begin
      opnd = {prefix_hi, src_data[7:0]};
    end
  end

  // Nibble swap inside every byte.
  genvar gb;
  generate
    for (gb = 0; gb < ACC_W / 8; gb++) begin : g_nib
      assign nswap[gb*8 +: 8] = {acc[gb*8 +: 4], acc[gb*8+4 +: 4]};
    end
  endgenerate

  // Borrow-chain subtract; borrow only counted for the borrow form.
  assign diff = {1'b0, acc} - {1'b0, opnd}
              - {{ACC_W{1'b0}}, (op_word[14:8] == `ACSLU_FLD_MINUS_SOURCE_BORROW) & flags_in.c};

  // Decode the instruction word into an operation kind.
  always_comb begin
    kind    = ACSLU_K_NONE;
    bit_op  = 1'b0;
    illegal = 1'b0;
    bit_idx = op_word[7:4];
    if (op_valid) begin
      case (op_word)
        `ACSLU_OP_ROT_R:    kind = ACSLU_K_RR;
        `ACSLU_OP_ROT_RC:   kind = ACSLU_K_RRC;
        `ACSLU_OP_SHL_1:    kind = ACSLU_K_SHL1;
        `ACSLU_OP_SHL_2:    kind = ACSLU_K_SHL2;
        `ACSLU_OP_SHL_4:    kind = ACSLU_K_SHL4;
        `ACSLU_OP_SHR_LOG:  kind = ACSLU_K_SHRL;
        `ACSLU_OP_SHR_AR1:  kind = ACSLU_K_SHRA1;
        `ACSLU_OP_SHR_AR2:  kind = ACSLU_K_SHRA2;
        `ACSLU_OP_SHR_AR4:  kind = ACSLU_K_SHRA4;
        `ACSLU_OP_NIB_SWP:  kind = ACSLU_K_NSWP;
        `ACSLU_OP_BYTE_SWP: begin
          // The narrow variant has no upper byte to exchange.
          if (ACC_W == 16) begin
            kind = ACSLU_K_BSWP;
          end else begin
            illegal = 1'b1;
          end
        end
        default: begin
          // The bit form shares bits 14:8 with the source XOR form, so it must win the decode.
          if (op_word[15:8] == `ACSLU_FLD_BIT_HI && op_word[3:0] == `ACSLU_FLD_BIT_LO) begin
            // Indexes past the accumulator width are refused, not wrapped.
            if (32'(bit_idx) < ACC_W) begin
              bit_op = 1'b1;
            end else begin
              illegal = 1'b1;
            end
          end else if (op_word[14:8] == `ACSLU_FLD_SUB) begin
            kind = ACSLU_K_SUB;
          end else if (op_word[14:8] == `ACSLU_FLD_MINUS_SOURCE_BORROW) begin
            kind = ACSLU_K_MINUS_SOURCE_BORROW;
          end else if (op_word[14:8] == `ACSLU_FLD_XOR) begin
            kind = ACSLU_K_XORS;
          end else begin
            illegal = 1'b1;
          end
        end
      endcase
    end
  end

  // Compute the result, the carry and which flags change.
  always_comb begin
    res   = acc;
    new_c = flags_in.c;
    up_d  = '0;
    case (kind)
      ACSLU_K_RR: begin
        res    = {acc[0], acc[ACC_W-1:1]};
        up_d.s = 1'b1;
      end
      ACSLU_K_RRC: begin
        res   = {flags_in.c, acc[ACC_W-1:1]};
        new_c = acc[0];
        up_d  = '{c: 1'b1, s: 1'b1, z: 1'b1, ov: 1'b0};
      end
      ACSLU_K_SHL1: begin
        res   = {acc[ACC_W-2:0], 1'b0};
        new_c = acc[ACC_W-1];
        up_d  = '{c: 1'b1, s: 1'b1, z: 1'b1, ov: 1'b0};
      end
      ACSLU_K_SHL2: begin
        res   = {acc[ACC_W-3:0], 2'h0};
        new_c = acc[ACC_W-2];
        up_d  = '{c: 1'b1, s: 1'b1, z: 1'b1, ov: 1'b0};
      end
      ACSLU_K_SHL4: begin
        res   = {acc[ACC_W-5:0], 4'h0};
        new_c = acc[ACC_W-4];
        up_d  = '{c: 1'b1, s: 1'b1, z: 1'b1, ov: 1'b0};
      end
      ACSLU_K_SHRL: begin
        res   = {1'b0, acc[ACC_W-1:1]};
        new_c = acc[0];
        up_d  = '{c: 1'b1, s: 1'b1, z: 1'b1, ov: 1'b0};
      end
      ACSLU_K_SHRA1: begin
        res   = {acc[ACC_W-1], acc[ACC_W-1:1]};
        new_c = acc[0];
        up_d  = '{c: 1'b1, s: 1'b0, z: 1'b1, ov: 1'b0};
      end
      ACSLU_K_SHRA2: begin
        res   = {{2{acc[ACC_W-1]}}, acc[ACC_W-1:2]};
        new_c = acc[1];
        up_d  = '{c: 1'b1, s: 1'b0, z: 1'b1, ov: 1'b0};
      end
      ACSLU_K_SHRA4: begin
        res   = {{4{acc[ACC_W-1]}}, acc[ACC_W-1:4]};
        new_c = acc[3];
        up_d  = '{c: 1'b1, s: 1'b0, z: 1'b1, ov: 1'b0};
      end
      ACSLU_K_SUB, ACSLU_K_MINUS_SOURCE_BORROW: begin
        res   = diff[ACC_W-1:0];
        new_c = diff[ACC_W];
        up_d  = '1;
      end
      ACSLU_K_BSWP: begin
        res    = {acc[ACC_W/2-1:0], acc[ACC_W-1:ACC_W/2]};
        up_d.s = 1'b1;
      end
      ACSLU_K_NSWP: begin
        res    = nswap;
        up_d.s = 1'b1;
      end
      ACSLU_K_XORS: begin
        res    = acc ^ opnd;
        up_d.s = 1'b1;
        up_d.z = 1'b1;
      end
      default: begin
        // Carry XOR bit form writes no accumulator and only the carry.
        if (bit_op) begin
          new_c  = flags_in.c ^ acc[bit_idx];
          up_d.c = 1'b1;
        end
      end
    endcase
  end

  // Next flag values; only the bits in the update mask carry meaning to the decoder.
  always_comb begin
    fl_d    = flags_in;
    fl_d.c  = new_c;
    fl_d.s  = res[ACC_W-1];
    fl_d.z  = (res == '0);
    // Signed fault: operands of unlike sign and result sign differs from the minuend.
    fl_d.ov = (acc[ACC_W-1] != opnd[ACC_W-1]) && (res[ACC_W-1] != acc[ACC_W-1]);
    res_d   = res;
    done_d  = (kind != ACSLU_K_NONE) || bit_op;
    ill_d   = illegal;
  end

  // Next accumulator contents; an operation beats a bus write to the same entry.
  always_comb begin
    for (int i = 0; i < NUM_ACC; i++) begin
      acc_d[i] = acc_q[i];
      if (bus_wr && bus_addr == PTR_W'(i)) begin
        acc_d[i] = bus_wdata[ACC_W-1:0];
      end
      if (kind != ACSLU_K_NONE && acc_pointer == PTR_W'(i)) begin
        acc_d[i] = res;
      end
    end
  end

  // Bus read data: narrow accumulators read with zeros above.
  always_comb begin
    rdata_d = '0;
    if (bus_rd) begin
      rdata_d[ACC_W-1:0] = acc_q[bus_addr];
    end
  end

  // Accumulator storage, one register per entry.
  genvar ga;
  generate
    for (ga = 0; ga < NUM_ACC; ga++) begin : g_acc
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          acc_q[ga] <= '0;
        end else begin
          acc_q[ga] <= acc_d[ga];
        end
      end
    end
  endgenerate

  // Output registers, written in the same edge as the accumulator.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= '0;
      res_q   <= '0;
      fl_q    <= '0;
      up_q    <= '0;
      done_q  <= 1'b0;
      ill_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      res_q   <= res_d;
      fl_q    <= fl_d;
      up_q    <= up_d;
      done_q  <= done_d;
      ill_q   <= ill_d;
    end
  end

  assign bus_rdata  = rdata_q;
  assign result     = res_q;
  assign flags_out  = fl_q;
  assign flags_upd  = up_q;
  assign op_done    = done_q;
  assign op_illegal = ill_q;

  // Helper copies of the inputs of the last cycle, read only by the checks below.
  logic [ACC_W-1:0]  h_acc_q;   // Accumulator operated on.
  logic              h_c_q;     // Carry going in.
  acslu_kind_t       h_kind_q;  // Kind executed.
  logic [PTR_W-1:0]  h_ptr_q;   // Pointer used.
  always_ff @(posedge clk) begin
    h_acc_q  <= acc;
    h_c_q    <= flags_in.c;
    h_kind_q <= kind;
    h_ptr_q  <= acc_pointer;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  rot_right_a: assert property (h_kind_q == ACSLU_K_RR && $past(op_valid) |->
    res_q == {h_acc_q[0], h_acc_q[ACC_W-1:1]} && up_q == '{c: 1'b0, s: 1'b1, z: 1'b0, ov: 1'b0})
    else $error("Rotate right result or flags wrong.");
  rot_carry_a: assert property ($past(kind) == ACSLU_K_RRC |->
    res_q[ACC_W-1] == h_c_q && fl_q.c == h_acc_q[0])
    else $error("Rotate through carry wrong.");
  rot_flags_a: assert property ((kind == ACSLU_K_RRC) |=> up_q.c && up_q.z && up_q.s)
    else $error("Rotate through carry flag mask wrong.");
  shl_four_a: assert property (h_kind_q == ACSLU_K_SHL4 && op_done |->
    res_q[3:0] == 4'h0 && fl_q.c == h_acc_q[ACC_W-4]) else $error("Left shift by four wrong.");
  shl_two_a: assert property (op_valid && op_word == `ACSLU_OP_SHL_2 ##1 1 |->
    res_q == {h_acc_q[ACC_W-3:0], 2'h0}) else $error("Left shift by two wrong.");
  shr_log_a: assert property (h_kind_q == ACSLU_K_SHRL && op_done |->
    !res_q[ACC_W-1] && fl_q.c == h_acc_q[0] && up_q.s) else $error("Logical right shift wrong.");
  shr_arith_a: assert property (h_kind_q == ACSLU_K_SHRA2 && op_done |->
    res_q[ACC_W-1 -: 3] == {3{h_acc_q[ACC_W-1]}} && fl_q.c == h_acc_q[1] && !up_q.s)
    else $error("Arithmetic right shift wrong.");
  sub_flags_a: assert property (h_kind_q == ACSLU_K_SUB && op_done |-> up_q == '1
    && fl_q.z == (res_q == '0) && fl_q.s == res_q[ACC_W-1]) else $error("Subtract flags wrong.");
  wr_back_a: assert property (op_done && !up_q.c |-> acc_q[h_ptr_q] == res_q)
    else $error("Active accumulator not written back.");
  bit_index_a: assert property (op_valid && op_word[15:8] == `ACSLU_FLD_BIT_HI &&
    op_word[3:0] == `ACSLU_FLD_BIT_LO && 32'(op_word[7:4]) >= ACC_W |=> op_illegal && !op_done)
    else $error("Out of range bit index accepted.");
  one_cycle_a: assert property (op_valid && !illegal |=> op_done)
    else $error("Operation did not finish in one cycle.");

  cov_minus_source_borrow_c: cover property (kind == ACSLU_K_MINUS_SOURCE_BORROW ##1 fl_q.ov);
  cov_rrc_c: cover property (kind == ACSLU_K_RRC ##1 kind == ACSLU_K_RRC);
  cov_bit_c: cover property (bit_op && flags_in.c);
  cov_bswp_c: cover property (kind == ACSLU_K_BSWP ##1 op_done);

endmodule : acslu_datapath

// ==== tb/acslu_flag_store.sv ====
// Flag storage model standing in for the decoder: keeps C, S, Z and OV for the datapath.
// Assumes op_done, flags_out and flags_upd come from the datapath on the same core clock.
`timescale 1ns/1ps

module acslu_flag_store
  import acslu_pkg::*;
(
  input  wire  logic         clk,       // Core clock.
  input  wire  logic         sys_rst,   // Synchronous reset, active high.
  input  wire  logic         op_done,   // An operation completed.
  input  wire  acslu_flags_t flags_out, // New flag values.
  input  wire  acslu_flags_t flags_upd, // Which flags the operation owns.
  output acslu_flags_t       flags_in   // Flags as the next operation sees them.
);
  acslu_flags_t flags_q; // Stored flags.
  acslu_flags_t flags_d; // Next stored flags.

  // Merge only the owned flags, so untouched flags keep their old value.
  always_comb begin
    flags_d = flags_q;
    if (op_done) begin
      flags_d = (flags_q & ~flags_upd) | (flags_out & flags_upd);
    end
  end

  // Forwarding the merge lets even a back-to-back operation see fresh flags.
  assign flags_in = flags_d;

  // Flag register, cleared by reset.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end
endmodule : acslu_flag_store

// ==== tb/tb.sv ====
// Self-checking bench of the accumulator datapath, wide variant, with a flag storage model.
// Assumes the package, the defines header and the datapath are compiled first.
`timescale 1ns/1ps
`include "acslu_defines.svh"

module tb
  import acslu_pkg::*;
;
  logic         clk, sys_rst, op_valid, src_is_byte, bus_wr, bus_rd, op_done, op_illegal; // Ports.
  logic [15:0]  op_word, src_data, bus_wdata, bus_rdata, result;                         // Data ports.
  logic [3:0]   acc_pointer, bus_addr;                                                   // Indexes.
  logic [7:0]   prefix_hi;                                                               // Prefix byte.
  acslu_flags_t flags_in, flags_out, flags_upd, ef;                                      // Flags.
  logic [15:0]  acc_m [16];                                                              // Expected accs.
  logic [15:0]  w, s;                                                                    // Stimulus.
  logic [3:0]   p;                                                                       // Pointer.
  logic [7:0]   prefix_register;                                                                     // Prefix.
  bit           byt;                                                                     // Byte source.
  int           seed = 32'h41D3;                                                         // Fixed seed.
  int           mismatches = 0;                                                          // Failures.
  int           tests_run = 0;                                                           // Checks.
  int           i, k;                                                                    // Loop vars.
  logic [15:0]  ops [11] = '{`ACSLU_OP_ROT_R, `ACSLU_OP_ROT_RC, `ACSLU_OP_SHL_1, `ACSLU_OP_SHL_2,
    `ACSLU_OP_SHL_4, `ACSLU_OP_SHR_LOG, `ACSLU_OP_SHR_AR1, `ACSLU_OP_SHR_AR2, `ACSLU_OP_SHR_AR4,
    `ACSLU_OP_BYTE_SWP, `ACSLU_OP_NIB_SWP}; // Fixed-code words, one per operation.

  acslu_datapath i_acslu_datapath (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid), .op_word(op_word),
    .acc_pointer(acc_pointer), .src_data(src_data), .src_is_byte(src_is_byte), .prefix_hi(prefix_hi),
    .flags_in(flags_in), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .result(result), .flags_out(flags_out), .flags_upd(flags_upd),
    .op_done(op_done), .op_illegal(op_illegal));
  acslu_flag_store i_acslu_flag_store (.clk(clk), .sys_rst(sys_rst), .op_done(op_done),
    .flags_out(flags_out), .flags_upd(flags_upd), .flags_in(flags_in));

  // Core clock, 10 ns period.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Counts one comparison and reports it at once if it failed.
  task automatic chk(input bit ok, input string msg);
    tests_run++;
    if (!ok) begin
      mismatches++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  // One-cycle bus write; the model copy is updated with it.
  task automatic bus_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
    acc_m[a] = d;
  endtask : bus_write

  // One-cycle bus read; data must stand in the next cycle only.
  task automatic bus_read(input logic [3:0] a);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 chk(bus_rdata === acc_m[a], "bus read data");
    @(posedge clk);
    #1 chk(bus_rdata === 16'h0000, "bus read data not released");
  endtask : bus_read

  // Works out result, new flags, owned-flag mask and refusal of one word.
  task automatic model(input logic [15:0] w, a, s, input acslu_flags_t f, output logic [15:0] r,
                       output acslu_flags_t nf, output logic [3:0] m, output bit ill);
    r = a;
    nf = f;
    m = 4'h0;
    ill = 1'b0;
    case (w)
      `ACSLU_OP_ROT_R:    begin r = {a[0], a[15:1]}; m = 4'h4; end
      `ACSLU_OP_ROT_RC:   begin r = {f.c, a[15:1]}; nf.c = a[0]; m = 4'hE; end
      `ACSLU_OP_SHL_1:    begin {nf.c, r} = {a, 1'b0}; m = 4'hE; end
      `ACSLU_OP_SHL_2:    begin {nf.c, r} = {a[14:0], 2'b00}; m = 4'hE; end
      `ACSLU_OP_SHL_4:    begin {nf.c, r} = {a[12:0], 4'h0}; m = 4'hE; end
      `ACSLU_OP_SHR_LOG:  begin {r, nf.c} = {1'b0, a}; m = 4'hE; end
      `ACSLU_OP_SHR_AR1:  begin {r, nf.c} = {a[15], a}; m = 4'hA; end
      `ACSLU_OP_SHR_AR2:  begin {r, nf.c} = {{2{a[15]}}, a[15:1]}; m = 4'hA; end
      `ACSLU_OP_SHR_AR4:  begin {r, nf.c} = {{4{a[15]}}, a[15:3]}; m = 4'hA; end
      `ACSLU_OP_BYTE_SWP: begin r = {a[7:0], a[15:8]}; m = 4'h4; end
      `ACSLU_OP_NIB_SWP:  begin r = {a[11:8], a[15:12], a[3:0], a[7:4]}; m = 4'h4; end
      default: begin
        // The bit form shares its top byte with a source form, so it is decoded first.
        if (w[15:8] == `ACSLU_FLD_BIT_HI && w[3:0] == `ACSLU_FLD_BIT_LO) begin
          nf.c = f.c ^ a[w[7:4]];
          m = 4'h8;
        end else if (w[14:8] == `ACSLU_FLD_SUB || w[14:8] == `ACSLU_FLD_MINUS_SOURCE_BORROW) begin
          {nf.c, r} = {1'b0, a} - {1'b0, s} - ((w[14:8] == `ACSLU_FLD_MINUS_SOURCE_BORROW) ? 17'(f.c) : 17'h0);
          nf.ov = (a[15] ^ s[15]) & (r[15] ^ a[15]);
          m = 4'hF;
        end else if (w[14:8] == `ACSLU_FLD_XOR) begin
          r = a ^ s;
          m = 4'h6;
        end else begin
          ill = 1'b1;
        end
      end
    endcase
    nf.s = r[15];
    nf.z = (r == 16'h0000);
  endtask : model

  // Issues one instruction and checks the answer in the cycle after it is taken.
  task automatic do_op(input logic [15:0] w, input logic [3:0] p, input logic [15:0] s, input bit byt,
                       input logic [7:0] prefix_register);
    logic [15:0]  r;
    acslu_flags_t nf;
    logic [3:0]   m;
    bit           ill;
    model(w, acc_m[p], byt ? {prefix_register, s[7:0]} : s, ef, r, nf, m, ill);
    @(posedge clk);
    op_valid <= 1'b1;
    op_word <= w;
    acc_pointer <= p;
    src_data <= s;
    src_is_byte <= byt;
    prefix_hi <= prefix_register;
    @(posedge clk);
    op_valid <= 1'b0;
    #1 chk(op_done === !ill && op_illegal === ill, "done or refusal pulse");
    chk(result === r, "result value");
    chk(flags_upd === m, "updated flag mask");
    chk((flags_out & m) === (nf & m), "flag values");
    if (!ill) begin
      acc_m[p] = r;
      ef = (ef & ~m) | (nf & m);
    end
  endtask : do_op

  // Main sequence: reset, bus fill, corner cases, then random operations.
  initial begin
    {op_valid, src_is_byte, bus_wr, bus_rd} = 4'h0;
    {op_word, src_data, bus_wdata, acc_pointer, bus_addr, prefix_hi} = '0;
    ef = '0;
    foreach (acc_m[j]) acc_m[j] = 16'h0000;
    sys_rst = 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    #1 chk(op_done === 1'b0 && result === 16'h0000 && flags_upd === 4'h0, "outputs after reset");
    bus_read(4'h7);
    for (i = 0; i < 16; i++) bus_write(4'(i), 16'($random(seed)));
    // Corner cases: zero results, sign fill, overflow, prefix byte, top bit index, refused word.
    bus_write(4'h1, 16'h0001);
    do_op(`ACSLU_OP_SHR_LOG, 4'h1, 16'h0000, 1'b0, 8'h00);
    bus_write(4'h2, 16'h8000);
    do_op(`ACSLU_OP_SHL_1, 4'h2, 16'h0000, 1'b0, 8'h00);
    bus_write(4'h3, 16'h8009);
    do_op(`ACSLU_OP_SHR_AR4, 4'h3, 16'h0000, 1'b0, 8'h00);
    do_op(`ACSLU_OP_ROT_RC, 4'h3, 16'h0000, 1'b0, 8'h00);
    bus_write(4'h4, 16'h8000);
    do_op({1'b0, `ACSLU_FLD_SUB, 8'h11}, 4'h4, 16'h0001, 1'b0, 8'h00);
    do_op({1'b1, `ACSLU_FLD_MINUS_SOURCE_BORROW, 8'h22}, 4'h4, 16'hA5FF, 1'b1, 8'h7F);
    do_op({`ACSLU_FLD_BIT_HI, 4'hF, `ACSLU_FLD_BIT_LO}, 4'h4, 16'h0000, 1'b0, 8'h00);
    do_op(16'h8A4A, 4'h5, 16'h0000, 1'b0, 8'h00);
    bus_read(4'h5);
    // Every kind once in order, then random kinds, pointers and sources.
    for (i = 0; i < 400; i++) begin
      k = (i < 16) ? i : {$random(seed)} % 16;
      s = 16'($random(seed));
      p = 4'($random(seed));
      prefix_register = 8'($random(seed));
      byt = 1'($random(seed));
      case (k)
        11: w = {s[15], `ACSLU_FLD_SUB, s[7:0]};
        12: w = {s[15], `ACSLU_FLD_MINUS_SOURCE_BORROW, s[7:0]};
        13: w = {1'b0, `ACSLU_FLD_XOR, s[7:0]};
        14: w = {`ACSLU_FLD_BIT_HI, s[11:8], `ACSLU_FLD_BIT_LO};
        15: w = 16'h8A4A;
        default: w = ops[k];
      endcase
      do_op(w, p, s, byt, prefix_register);
      if (i % 8 == 7) bus_read(p);
    end
    @(posedge clk);
    print_verdict();
  end

  // Cuts a hang short well beyond the expected thousand or so cycles.
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
endmodule : tb
